/* core/wsr_core.sv */
// wsr_core: suspend, wake, cable-detach and chip reset control with axi4-lite registers
`timescale 1ns/1ps
`default_nettype none
// Contract
// - energy powerdown stops phy, activity raises irq
// - energy status bit wakes; sticky while irq
// - energy while armed returns normal, remote wake
// - set pin7 status wakes immediately once armed
// - linkup wakes, ignores pin, sets pin7 status
// - frame status bit wakes; sticky while event
// - good frame in state three wakes
// - cable detach detaches usb, stops pll
// - link or gpio reattaches without software
// - readable cable detach status bit
// - power-on holds reset 22ms, then load
// - power-on leaves phy general powerdown
// - pin reset; ready zero until done
// - pin reset puts phy general powerdown
// - pin reset ignored while unpowered
// - frame-match wake only state zero, energy one
module wsr_core #(
  parameter int POR_CYCLES = wsr_pkg::POR_HOLD_CYC  // shorten in simulation
) (
  // clock and bus reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address / data / response
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // asynchronous chip-side inputs
  input  wire logic        ext_reset_n,     // external reset pin
  input  wire logic        vbus_present,    // high while powered
  input  wire logic        usb_suspend,     // host suspend signalling seen
  input  wire logic        phy_irq_status,  // phy internal interrupt
  input  wire logic        phy_link_up,     // phy link status
  input  wire logic        mac_wake_event,  // mac frame-match wake
  input  wire logic        mac_good_frame,  // frame passed mac filters
  input  wire logic        gpio_attach,     // programmed gpio for reattach
  // control outputs
  output logic             remote_wake,     // one-cycle remote wake pulse
  output logic             usb_attached,    // pull-up connected
  output logic             usb_pll_on,      // usb pll enable
  output logic             phy_powerdown,   // phy general power-down
  output logic             phy_energy_detect_powerdown,        // phy energy-detect powerdown
  output logic             chip_reset_n,    // internal reset to rest of chip
  output logic             eeprom_load      // eeprom load in progress
);

  // ---------------------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------------------
  logic [7:0] raw_in;
  logic [7:0] syn;
  assign raw_in = {gpio_attach, mac_good_frame, mac_wake_event, phy_link_up,
                   phy_irq_status, usb_suspend, vbus_present, ext_reset_n};

  wsr_sync #(.W(8)) u_sync (
    .aclk (aclk),
    .d    (raw_in),
    .q    (syn)
  );

  wire pin_rst_n = syn[0];
  wire powered   = syn[1];
  wire susp_in   = syn[2];
  wire phy_irq   = syn[3];
  wire link_up   = syn[4];
  wire mac_evt   = syn[5];
  wire good_frm  = syn[6];
  wire gpio_att  = syn[7];

  // ---------------------------------------------------------------------------
  // reset sequencer
  // ---------------------------------------------------------------------------
  wsr_pkg::wsr_seq_t seq_r, seq_nxt;
  logic [31:0]       cnt_r, cnt_nxt;   // hold / load timer
  logic              was_off_r;        // power was absent: full power-on reset
  // pin reset counts only while powered
  wire pin_hit  = powered && !pin_rst_n;
  wire restart  = !powered || pin_hit;
  wire running  = (seq_r == wsr_pkg::WSR_RUN);

  // next-state logic of the sequencer
  always_comb begin
    seq_nxt = seq_r;
    cnt_nxt = cnt_r;
    if (restart) begin
      seq_nxt = wsr_pkg::WSR_HOLD;
      cnt_nxt = 32'h0;
    end else begin
      case (seq_r)
        wsr_pkg::WSR_HOLD: begin
          // power-on holds the full timer, pin reset releases at once
          if (!was_off_r || cnt_r >= 32'(POR_CYCLES - 1)) begin
            seq_nxt = wsr_pkg::WSR_LOAD;
            cnt_nxt = 32'h0;
          end else begin
            cnt_nxt = cnt_r + 32'h1;
          end
        end
        wsr_pkg::WSR_LOAD: begin
          if (cnt_r >= 32'(wsr_pkg::LOAD_CYC - 1)) begin
            seq_nxt = wsr_pkg::WSR_RUN;
          end else begin
            cnt_nxt = cnt_r + 32'h1;
          end
        end
        wsr_pkg::WSR_RUN: begin
          seq_nxt = seq_r;
        end
        default: begin
          seq_nxt = wsr_pkg::WSR_HOLD;
        end
      endcase
    end
  end

  // sequencer registers; bus reset counts as power-on
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_r     <= wsr_pkg::WSR_HOLD;
      cnt_r     <= 32'h0;
      was_off_r <= 1'b1;
    end else begin
      seq_r     <= seq_nxt;
      cnt_r     <= cnt_nxt;
      if (!powered) begin
        was_off_r <= 1'b1;
      end else if (running) begin
        was_off_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------------------
  logic [1:0] sel_r;          // suspend select, held across wake
  logic       ws0_r, ws1_r;   // wake_status_bits
  logic       eden_r, fwen_r; // energy / frame wake enables
  logic       epd_r, gpd_r;   // energy powerdown ctrl, general powerdown
  logic       cden_r, cdst_r; // cable detach enable / status
  logic       p7st_r;         // pin7_irq_status
  logic [5:0] gwk_r;          // pin-7 wake config
  logic [4:0] wuc_r;          // frame-match enables
  logic       susp_r;         // device in suspend
  logic       susp_d_r;       // suspend signalling one cycle ago, for its rising edge
  logic       det_r;          // detached (cable_detach_mode)
  logic       chip_rst_r;     // chip logic in reset

  // write channel acceptance: take address and data each on its own, write once both are held
  logic       aw_r, w_r;
  logic [7:0] awa_r;
  logic [31:0] wd_r;
  logic [3:0] ws_r;
  wire  do_wr = aw_r && w_r && !s_axi_bvalid;
  wire  wr_ok = (awa_r <= wsr_pkg::EVT_OFS) && (awa_r[1:0] == 2'h0);
  wire  wb0   = do_wr && wr_ok && ws_r[0];
  wire  wb1   = do_wr && wr_ok && ws_r[1];
  wire  w_pmc = wb0 && (awa_r == wsr_pkg::PMC_OFS);
  wire  w_pmh = wb1 && (awa_r == wsr_pkg::PMC_OFS);
  wire  w_hwc = wb0 && (awa_r == wsr_pkg::HWC_OFS);
  wire  w_ist = wb0 && (awa_r == wsr_pkg::IST_OFS);
  wire  w_ish = wb1 && (awa_r == wsr_pkg::IST_OFS);
  wire  w_gwk = wb0 && (awa_r == wsr_pkg::GWK_OFS);
  wire  w_wuc = wb0 && (awa_r == wsr_pkg::WUC_OFS);

  // wake source decode
  wire st0 = susp_r && (sel_r == wsr_pkg::SEL_ZERO);
  wire st1 = susp_r && (sel_r == wsr_pkg::SEL_ONE);
  wire st3 = susp_r && (sel_r == wsr_pkg::SEL_THREE);
  wire lu_arm  = gwk_r[wsr_pkg::GWK_LUEN] && gwk_r[wsr_pkg::GWK_P7WK];
  // link-up drives pin-7 status, external pin level ignored
  wire lu_evt  = lu_arm && link_up && (st0 || st3);
  wire fm_en   = |wuc_r;
  // mac event sets the frame status whatever the enables, so it cannot be cleared under it
  wire ws1_set = mac_evt || (good_frm && !fm_en);
  wire wk_en   = eden_r && ws0_r && (st1 || !susp_r);
  wire wk_fm   = fwen_r && ws1_r && fm_en && st0;
  wire wk_gf   = ws1_r && !fm_en && st3;
  wire wk_p7   = lu_arm && p7st_r && (st0 || st3);
  // energy wake only from state one
  wire wake    = susp_r && ((wk_en && st1) || wk_fm || wk_gf || wk_p7);

  // status flag updates: hardware set beats software clear
  always_ff @(posedge aclk) begin
    if (!aresetn || chip_rst_r) begin
      ws0_r  <= 1'b0;
      ws1_r  <= 1'b0;
      p7st_r <= 1'b0;
    end else begin
      // energy status stays set while phy interrupt high
      ws0_r  <= phy_irq || (ws0_r && !(w_pmc && wd_r[wsr_pkg::PMC_WS0]));
      // frame status stays set while mac event high
      ws1_r  <= ws1_set || (ws1_r && !(w_pmc && wd_r[wsr_pkg::PMC_WS1]));
      p7st_r <= lu_evt || (p7st_r && !(w_ist && wd_r[wsr_pkg::IST_P7]));
    end
  end

  // software control fields
  always_ff @(posedge aclk) begin
    if (!aresetn || chip_rst_r) begin
      sel_r  <= wsr_pkg::SEL_ZERO;
      eden_r <= 1'b0;
      fwen_r <= 1'b0;
      epd_r  <= wsr_pkg::PMC_RST[wsr_pkg::PMC_EPD];
      gpd_r  <= wsr_pkg::PMC_RST[wsr_pkg::PMC_GPD];  // general pd after reset
      cden_r <= 1'b0;
      gwk_r  <= 6'h00;
      wuc_r  <= 5'h00;
    end else begin
      if (w_pmc) begin
        eden_r <= wd_r[wsr_pkg::PMC_EDEN];
        fwen_r <= wd_r[wsr_pkg::PMC_FWEN];
        sel_r  <= wd_r[wsr_pkg::PMC_SUSLO +: 2];
        epd_r  <= wd_r[wsr_pkg::PMC_EPD];
      end
      if (w_pmh) begin
        gpd_r  <= wd_r[wsr_pkg::PMC_GPD];
      end
      if (w_hwc) begin
        cden_r <= wd_r[wsr_pkg::HWC_CDEN];
      end else if (det_r && (link_up || gpio_att)) begin
        cden_r <= 1'b0;
      end
      if (w_gwk) begin
        gwk_r  <= wd_r[5:0];
      end
      if (w_wuc) begin
        wuc_r  <= wd_r[4:0];
      end
    end
  end

  // suspend, detach and chip reset state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      susp_r     <= 1'b0;
      susp_d_r   <= 1'b0;
      det_r      <= 1'b0;
      cdst_r     <= 1'b0;
      chip_rst_r <= 1'b1;
    end else begin
      chip_rst_r <= !running;
      susp_d_r   <= susp_in;
      if (chip_rst_r) begin
        susp_r <= 1'b0;
        det_r  <= 1'b0;
      end else begin
        // wake wins; enter on the rising edge of suspend, so a wake is not undone
        // by signalling the host has not yet dropped; leave when the host resumes
        if (wake) begin
          susp_r <= 1'b0;
        end else if (susp_in && !susp_d_r) begin
          susp_r <= 1'b1;
        end else if (!susp_in) begin
          susp_r <= 1'b0;
        end
        // detach on enable, reattach on link or gpio
        if (det_r && (link_up || gpio_att)) begin
          det_r  <= 1'b0;
          cdst_r <= 1'b1;
        end else if (cden_r && !det_r) begin
          det_r  <= 1'b1;
        end else if (w_hwc && wd_r[wsr_pkg::HWC_CDST]) begin
          cdst_r <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      remote_wake   <= 1'b0;
      usb_attached  <= 1'b0;
      usb_pll_on    <= 1'b0;
      phy_powerdown <= 1'b1;
      phy_energy_detect_powerdown      <= 1'b0;
      chip_reset_n  <= 1'b0;
      eeprom_load   <= 1'b0;
    end else begin
      remote_wake   <= wake && !chip_rst_r;
      usb_attached  <= running && !det_r;
      usb_pll_on    <= running && !det_r;
      phy_powerdown <= !running || gpd_r;
      phy_energy_detect_powerdown      <= running && !epd_r;
      chip_reset_n  <= (seq_r != wsr_pkg::WSR_HOLD);
      eeprom_load   <= (seq_r == wsr_pkg::WSR_LOAD);
    end
  end

  // ---------------------------------------------------------------------------
  // axi4-lite slave
  // ---------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_r          <= 1'b0;
      w_r           <= 1'b0;
      awa_r         <= 8'h00;
      wd_r          <= 32'h0;
      ws_r          <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= wsr_pkg::AXI_OKAY;
    end else begin
      // ready flops always mirror a free slot
      if (s_axi_awvalid && s_axi_awready) begin
        aw_r          <= 1'b1;
        awa_r         <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_r          <= 1'b1;
        wd_r         <= s_axi_wdata;
        ws_r         <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        aw_r          <= 1'b0;
        w_r           <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? wsr_pkg::AXI_OKAY : wsr_pkg::AXI_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // read data mux
  wire [31:0] pmc_rd = {22'h0, susp_r, gpd_r, epd_r, sel_r, fwen_r, eden_r,
                        ws1_r, ws0_r, running};
  wire [31:0] hwc_rd = {29'h0, !det_r, cdst_r, cden_r};
  wire [31:0] ist_rd = {23'h0, phy_irq, p7st_r, 7'h00};
  wire [31:0] evt_rd = {26'h0, gpio_att, good_frm, mac_evt, link_up, phy_irq, susp_in};
  wire [7:0]  ra     = s_axi_araddr;
  wire        rd_ok  = (ra <= wsr_pkg::EVT_OFS) && (ra[1:0] == 2'h0);
  wire [31:0] rd_mux = (ra == wsr_pkg::PMC_OFS) ? pmc_rd :
                       (ra == wsr_pkg::HWC_OFS) ? hwc_rd :
                       (ra == wsr_pkg::IST_OFS) ? ist_rd :
                       (ra == wsr_pkg::GWK_OFS) ? {26'h0, gwk_r} :
                       (ra == wsr_pkg::WUC_OFS) ? {27'h0, wuc_r} :
                       (ra == wsr_pkg::EVT_OFS) ? evt_rd : 32'h0;

  // read channel: one beat at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp   <= wsr_pkg::AXI_OKAY;
      s_axi_arready <= 1'b1;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_ok ? wsr_pkg::AXI_OKAY : wsr_pkg::AXI_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule
`default_nettype wire

/* core/wsr_pkg.sv */
// wsr_pkg: register map, field positions, reset values and timing constants
package wsr_pkg;

  // ---------------------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] PMC_OFS  = 8'h00; // power_mgmt_control_reg
  localparam logic [7:0] HWC_OFS  = 8'h04; // hardware_config_reg
  localparam logic [7:0] IST_OFS  = 8'h08; // interrupt_status_reg
  localparam logic [7:0] GWK_OFS  = 8'h0C; // pin-7 wake config
  localparam logic [7:0] WUC_OFS  = 8'h10; // wakeup_control_reg
  localparam logic [7:0] EVT_OFS  = 8'h14; // live event view

  // ---------------------------------------------------------------------------
  // power_mgmt_control_reg fields
  // ---------------------------------------------------------------------------
  localparam int PMC_READY  = 0;  // ready flag
  localparam int PMC_WS0    = 1;  // wake_status_bits[0], energy
  localparam int PMC_WS1    = 2;  // wake_status_bits[1], frame
  localparam int PMC_EDEN   = 3;  // energy_wake_enable
  localparam int PMC_FWEN   = 4;  // frame_wake_enable
  localparam int PMC_SUSLO  = 5;  // suspend select, 2 bits
  localparam int PMC_EPD    = 7;  // energy_powerdown_ctrl (0 = powerdown on)
  localparam int PMC_GPD    = 8;  // phy general power-down (read/write)
  localparam int PMC_SUSP   = 9;  // read-only: device suspended

  // hardware_config_reg fields
  localparam int HWC_CDEN   = 0;  // cable_detach_enable
  localparam int HWC_CDST   = 1;  // cable_detach_status (write 1 clears)
  localparam int HWC_ATT    = 2;  // read-only: attached to usb

  // interrupt_status_reg fields
  localparam int IST_P7     = 7;  // pin7_irq_status (write 1 clears)
  localparam int IST_PHY    = 8;  // read-only: phy_irq_status level

  // pin-7 wake config fields
  localparam int GWK_LUEN   = 0;  // linkup_wake_enable
  localparam int GWK_P7WK   = 1;  // pin7_wake_enable
  localparam int GWK_P7POL  = 2;  // pin7_wake_polarity
  localparam int GWK_P7EN   = 3;  // pin7_enable
  localparam int GWK_P7DIR  = 4;  // pin7_direction
  localparam int GWK_P7BUF  = 5;  // pin7_buffer_type

  // suspend select encodings
  localparam logic [1:0] SEL_ZERO  = 2'h0;
  localparam logic [1:0] SEL_ONE   = 2'h1;
  localparam logic [1:0] SEL_THREE = 2'h3;

  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int CLK_HZ        = 20_000_000;
  localparam int POR_HOLD_MS   = 22;
  localparam int POR_HOLD_CYC  = (CLK_HZ / 1000) * POR_HOLD_MS;
  localparam int LOAD_CYC      = 16;   // eeprom load duration, cycles

  // reset values
  localparam logic [9:0] PMC_RST = 10'h180;  // powerdown off, general pd on
  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  // sequencer states, gray along init path
  typedef enum logic [1:0] {
    WSR_HOLD = 2'b00,
    WSR_LOAD = 2'b01,
    WSR_RUN  = 2'b11
  } wsr_seq_t;

endpackage

/* core/wsr_sync.sv */
// wsr_sync: two-flop synchroniser for a bank of asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module wsr_sync #(
  parameter int W = 1
) (
  // clock
  input  wire logic         aclk,
  // asynchronous inputs
  input  wire logic [W-1:0] d,
  // synchronised outputs
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;  // first stage, read only by q

  // two flops in series, no reset needed
  always_ff @(posedge aclk) begin
    meta_r <= d;
    q      <= meta_r;
  end

endmodule
`default_nettype wire

/* test/wsr_core_asserts.sv */
// wsr_core_asserts: sequencing and bus checks on the wsr_core ports
`timescale 1ns/1ps
`default_nettype none
module wsr_core_asserts (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // bus answers
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // chip-side outputs
  input wire logic        remote_wake,
  input wire logic        usb_attached,
  input wire logic        usb_pll_on,
  input wire logic        phy_powerdown,
  input wire logic        phy_energy_detect_powerdown,
  input wire logic        chip_reset_n,
  input wire logic        eeprom_load
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ---------------------------------------------------------------------------
  // reset sequencing
  // ---------------------------------------------------------------------------
  por_start_a: assert property ($rose(aresetn) |-> phy_powerdown && !chip_reset_n)
    else $error("chip not held at reset release");
  por_hold_a: assert property ($rose(aresetn) |-> !chip_reset_n [*8])
    else $error("chip reset dropped too early");
  load_follows_a: assert property ($rose(chip_reset_n) |-> eeprom_load)
    else $error("no load after reset hold");
  load_len_a: assert property ($rose(eeprom_load) |-> ##15 eeprom_load ##1 !eeprom_load)
    else $error("load length wrong");
  pd_reset_a: assert property (!chip_reset_n |-> phy_powerdown && !phy_energy_detect_powerdown)
    else $error("phy not powered down in reset");
  // ---------------------------------------------------------------------------
  // usb side and bus
  // ---------------------------------------------------------------------------
  detach_pll_a: assert property (usb_pll_on == usb_attached && (!usb_attached || chip_reset_n))
    else $error("pll and attach disagree");
  wake_pulse_a: assert property (remote_wake |=> !remote_wake)
    else $error("remote wake longer than one cycle");
  wake_run_a: assert property ($rose(remote_wake) |-> chip_reset_n)
    else $error("wake while chip in reset");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  // main scenarios
  cover property ($rose(remote_wake));
  cover property ($rose(usb_attached));
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
`default_nettype wire

/* test/wsr_core_tb_top.sv */
// wsr_core_tb_top: register-level tests of wake, detach and reset control
`timescale 1ns/1ps
`default_nettype none
module wsr_core_tb_top;
  localparam logic [7:0] PMC = wsr_pkg::PMC_OFS, HWC = wsr_pkg::HWC_OFS, IST = wsr_pkg::IST_OFS;
  localparam logic [7:0] GWK = wsr_pkg::GWK_OFS, WUC = wsr_pkg::WUC_OFS;
  localparam logic [1:0] OK = wsr_pkg::AXI_OKAY, ERR = wsr_pkg::AXI_SLVERR;
  logic        aclk = 1'b0, aresetn = 1'b0, ext_rst_n = 1'b1, vbus = 1'b1, gpio_att = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  src = 4'h0; // mac wake, good frame, link up, phy irq
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, hgo = 1'b0, usb_sus;
  logic        rwake, att, pll_on, phy_pd, energy_detect_powerdown, chip_rst_n, eep_load;
  int          num_errors = 0, comparisons = 0;
  // wake table: suspend select, source, wake expected
  logic [1:0]  sel_t [9] = '{2'h1, 2'h0, 2'h3, 2'h0, 2'h1, 2'h3, 2'h0, 2'h0, 2'h1};
  logic [3:0]  src_t [9] = '{4'h1, 4'h1, 4'h2, 4'h2, 4'h2, 4'h4, 4'h4, 4'h8, 4'h8};
  logic        exp_t [9] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  wsr_core #(.POR_CYCLES(20)) i_wsr_core (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ext_reset_n(ext_rst_n), .vbus_present(vbus), .usb_suspend(usb_sus),
    .phy_irq_status(src[0]), .phy_link_up(src[1]), .mac_good_frame(src[2]),
    .mac_wake_event(src[3]), .gpio_attach(gpio_att),
    .remote_wake(rwake), .usb_attached(att), .usb_pll_on(pll_on), .phy_powerdown(phy_pd),
    .phy_energy_detect_powerdown(energy_detect_powerdown), .chip_reset_n(chip_rst_n), .eeprom_load(eep_load));
  wsr_host_model i_wsr_host_model (
    .aclk(aclk), .suspend_req(hgo), .remote_wake(rwake), .usb_suspend(usb_sus));
  initial forever #25 aclk = ~aclk;
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // axi4-lite write, both channels offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask
  // axi4-lite read, masked compare
  task automatic rd(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk(rdata & m, e);
    chk({30'h0, rresp}, {30'h0, er});
  endtask
  // cycles until the chip runs again
  task automatic wait_run(output int n);
    for (n = 0; n < 300 && !(chip_rst_n === 1'b1 && eep_load === 1'b0); n++) @(posedge aclk);
  endtask
  task automatic complete_run;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    int n;
    logic wk;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    wait_run(n);
    chk({31'h0, n >= 36 && n <= 40}, 32'h1);
    rd(PMC, 32'h3FF, 32'h181, OK);
    chk({31'h0, energy_detect_powerdown}, 32'h0);
    rd(8'h20, 32'hFFFFFFFF, 32'h0, ERR);
    wr(8'h02, 32'hFFFFFFFF, ERR);
    wr(PMC, 32'h0, OK);
    repeat (3) @(posedge aclk);
    chk({31'h0, energy_detect_powerdown}, 32'h1);
    wr(WUC, 32'h0, OK);
    wr(GWK, 32'h3, OK);
    // wake sources against each suspend select
    for (int i = 0; i < 9; i++) begin
      // last two rows: frame-match wake with one match enable set
      if (i == 7) wr(WUC, 32'h1, OK);
      // arm only while every mac and phy source is quiet
      wr(PMC, {25'h0, sel_t[i], 5'h18}, OK);
      hgo <= 1'b1;
      repeat (6) @(posedge aclk);
      rd(PMC, 32'h200, 32'h200, OK);
      src <= src_t[i];
      wk = 1'b0;
      repeat (20) begin
        @(posedge aclk);
        if (rwake === 1'b1) wk = 1'b1;
      end
      chk({31'h0, wk}, {31'h0, exp_t[i]});
      src <= 4'h0;
      hgo <= 1'b0;
      repeat (4) @(posedge aclk);
      rd(PMC, 32'h60, {25'h0, sel_t[i], 5'h0}, OK);
      rd(IST, 32'h80, {24'h0, exp_t[i] & src_t[i][1], 7'h0}, OK);
      wr(PMC, {25'h0, sel_t[i], 5'h0E}, OK);
      wr(IST, 32'h80, OK);
    end
    // status bits refuse clearing while their source is high
    for (int j = 0; j < 2; j++) begin
      src <= j ? 4'h8 : 4'h1;
      repeat (4) @(posedge aclk);
      wr(PMC, 32'h2 << j, OK);
      rd(PMC, 32'h2 << j, 32'h2 << j, OK);
      src <= 4'h0;
      repeat (4) @(posedge aclk);
      wr(PMC, 32'h2 << j, OK);
      rd(PMC, 32'h2 << j, 32'h0, OK);
    end
    // cable detach, reattach by link then by gpio
    for (int k = 0; k < 2; k++) begin
      wr(HWC, 32'h1, OK);
      repeat (6) @(posedge aclk);
      chk({31'h0, att}, 32'h0);
      if (k != 0) gpio_att <= 1'b1;
      else src <= 4'h2;
      for (n = 0; n < 20 && att !== 1'b1; n++) @(posedge aclk);
      chk({31'h0, att}, 32'h1);
      rd(HWC, 32'h7, 32'h6, OK);
      gpio_att <= 1'b0;
      src <= 4'h0;
      wr(HWC, 32'h2, OK);
    end
    // pin reset
    ext_rst_n <= 1'b0;
    repeat (4) @(posedge aclk);
    rd(PMC, 32'h101, 32'h100, OK);
    ext_rst_n <= 1'b1;
    wait_run(n);
    rd(PMC, 32'h3FF, 32'h181, OK);
    chk({31'h0, phy_pd}, 32'h1);
    // power loss with a pin pulse inside it
    vbus <= 1'b0;
    repeat (4) @(posedge aclk);
    ext_rst_n <= 1'b0;
    repeat (3) @(posedge aclk);
    ext_rst_n <= 1'b1;
    vbus <= 1'b1;
    wait_run(n);
    chk({31'h0, n >= 36 && n <= 44}, 32'h1);
    complete_run;
  end
  // hang guard
  initial begin
    repeat (6000) @(posedge aclk);
    num_errors++;
    complete_run;
  end
endmodule
bind wsr_core wsr_core_asserts i_wsr_core_asserts (
  .aclk, .aresetn, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .remote_wake, .usb_attached, .usb_pll_on, .phy_powerdown, .phy_energy_detect_powerdown,
  .chip_reset_n, .eeprom_load);
`default_nettype wire

/* test/wsr_host_model.sv */
// wsr_host_model: usb host side, sends suspend signalling and resumes on remote wake
`timescale 1ns/1ps
`default_nettype none
module wsr_host_model (
  // clock
  input  wire logic aclk,
  // bench request and device answer
  input  wire logic suspend_req,
  input  wire logic remote_wake,
  // suspend signalling to the device
  output var logic  usb_suspend
);
  logic sus_r   = 1'b0; // suspend level on the bus
  logic woken_r = 1'b0; // wake seen in this episode
  assign usb_suspend = sus_r;
  // suspend only after the bench has armed the device, resume on wake
  always @(posedge aclk) begin
    if (!suspend_req) begin
      sus_r   <= 1'b0;
      woken_r <= 1'b0;
    end else if (remote_wake) begin
      sus_r   <= 1'b0;
      woken_r <= 1'b1;
    end else if (!woken_r) begin
      sus_r   <= 1'b1;
    end
  end
endmodule
`default_nettype wire
